// ---- hw/host_port_defines.svh ----
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define PORT_ADDR_WIDTH 16
`define PORT_DATA_WIDTH 16
`define DISPLAY_MEM_END 16'hA000
`define DISPLAY_MEM_WORDS 20480
`define REG_BLOCK_BASE 16'hFFE0
`define REG_BLOCK_WORDS 16
`define STROBE_MODE_CODE 3'h7
`define STROBE_MODE_BUS_STATE 1'h0
`define READ_FILL 16'h0000
`define STRAP_SETTLE_EDGES 2'h2
`endif

// ---- hw/host_port_pkg.sv ----
package host_port_pkg;
  typedef enum logic [1:0] {
    l_idle = 2'h0,
    l_busy = 2'h1,
    l_done = 2'h3,
    l_hold = 2'h2
  } link_phase_type;

  typedef struct packed {
    link_phase_type phase;
    logic ok_s1;
    logic ok_s2;
    logic big_s1;
    logic big_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic req_tgl;
    logic write;
    logic [1:0] be;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } link_state_type;

  typedef struct packed {
    logic [5:0] strap_s1;
    logic [5:0] strap_s2;
    logic taken;
    logic [1:0] settle;
    logic [2:0] mode;
    logic bus_state;
    logic big;
    logic polarity;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic power;
  } core_state_type;

  typedef struct packed {
    logic pending;
    logic write;
    logic [1:0] be;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic [15:0] refresh_data;
    logic refresh_grant;
  } store_state_type;
endpackage : host_port_pkg

// ---- hw/store_if.sv ----
`timescale 1ns/1ps
interface store_if;
  logic start;
  logic write;
  logic [1:0] be;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport core (output start, write, be, addr, wdata, input rdata, done);
  modport store (input start, write, be, addr, wdata, output rdata, done);
endinterface : store_if

// ---- hw/core_store.sv ----
`timescale 1ns/1ps
`include "host_port_defines.svh"
module core_store (
  input wire logic ref_clk,
  input wire logic rst,
  store_if.store acc,
  input wire logic refresh_req,
  input wire logic [15:0] refresh_addr,
  output logic [15:0] refresh_data,
  output logic refresh_grant
);
  // ****************************************
  // Storage and arbitration
  // ****************************************
  logic [15:0] mem [`DISPLAY_MEM_WORDS];
  logic [15:0] regs [`REG_BLOCK_WORDS];
  host_port_pkg::store_state_type s;
  host_port_pkg::store_state_type next_s;
  logic svc_host;

  function automatic logic [1:0] region(input logic [15:0] a);
    region = 2'h0;
    if (a < `DISPLAY_MEM_END) region = 2'h1; // RL14
    else if (a >= `REG_BLOCK_BASE) region = 2'h2; // RL14
  endfunction : region

  function automatic logic [15:0] fetch(input logic [15:0] a);
    fetch = `READ_FILL;
    if (region(a) == 2'h1) fetch = mem[a[15:1]];
    else if (region(a) == 2'h2) fetch = regs[a[4:1]];
  endfunction : fetch

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.refresh_grant = 1'b0;
    svc_host = 1'b0;
    if (acc.start) begin
      next_s.pending = 1'b1;
      next_s.write = acc.write;
      next_s.be = acc.be;
      next_s.addr = acc.addr;
      next_s.wdata = acc.wdata;
    end
    // Refresh owns the array; host keeps waiting
    if (refresh_req) begin // RL8
      next_s.refresh_data = fetch(refresh_addr);
      next_s.refresh_grant = 1'b1;
    end else if (s.pending) begin
      svc_host = 1'b1;
      next_s.pending = 1'b0;
      next_s.done = 1'b1;
      next_s.rdata = s.write ? s.rdata : fetch(s.addr);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // No reset on the arrays; contents are undefined at power-up
  always_ff @(posedge ref_clk) begin
    if (svc_host && s.write) begin
      for (int b = 0; b < 2; b++) begin
        if (s.be[b] && region(s.addr) == 2'h1)
          mem[s.addr[15:1]][b*8 +: 8] <= s.wdata[b*8 +: 8];
        if (s.be[b] && region(s.addr) == 2'h2)
          regs[s.addr[4:1]][b*8 +: 8] <= s.wdata[b*8 +: 8];
      end
    end
  end

  assign acc.rdata = s.rdata;
  assign acc.done = s.done;
  assign refresh_data = s.refresh_data;
  assign refresh_grant = s.refresh_grant;

  a_refresh_wins: assert property (@(posedge ref_clk) disable iff (rst)
    (refresh_req && s.pending) |=> (!s.done && s.pending)) // RL8
    else $error("host served during refresh");
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (svc_host && !s.write && region(s.addr) == 2'h0)
    |=> (s.rdata == `READ_FILL)) // RL14
    else $error("unmapped read not zero");
endmodule : core_store

// ---- hw/host_port.sv ----
`timescale 1ns/1ps
`include "host_port_defines.svh"
// How it works
// RL1 - Pin side runs on its own bus clock, apart from the core clock.
// RL2 - Host wires sixteen address and data lines straight to its buses.
// RL3 - Big-endian 32-bit hosts use high lanes; others use low lanes.
// RL4 - Outside logic makes low and high byte write strobes, active low.
// RL5 - Outside logic makes low and high byte read strobes, active low.
// RL6 - Host decodes its high address lines into our chip select.
// RL7 - Wait stays low until read data is valid or write taken.
// RL8 - Refresh collision keeps wait low until arbitration grants the host.
// RL9 - Bus-state pin ignored during cycles; tied low for strobe mode.
// RL10 - Straps and bus-state sampled at reset release, then held.
// RL11 - Byte-order strap: zero little-endian, one big-endian.
// RL12 - Polarity strap: zero panel power active low, one active high.
// RL13 - Mode straps 111 with bus-state low select strobe mode.
// RL14 - 64K window: memory from base, registers in last 32 bytes.
// RL15 - Address bits above the window are ignored, image repeats.
// RL16 - Glue inverts wait into host acknowledge, gated by chip select.
// RL17 - Host select unit: 16-bit port, no wait states, no auto ack.
// RL18 - Host select unit: no bursts, byte enables on writes only.
// RL19 - Host ends transfer on acknowledge, waits for its release.
// RL20 - Each host transaction lasts at least two bus clocks.
// RL21 - Read data held stable in the cycle wait goes high.
module host_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic host_port_clock,
  input wire logic chip_select_n,
  input wire logic [15:0] port_addr,
  input wire logic [15:0] port_data_in,
  output logic [15:0] port_data_out,
  output logic port_data_oe,
  input wire logic write_strobe_low_n,
  input wire logic write_strobe_high_n,
  input wire logic read_strobe_low_n,
  input wire logic read_strobe_high_n,
  output logic wait_n,
  input wire logic [2:0] bus_mode_straps,
  input wire logic byte_order_strap,
  input wire logic panel_power_polarity_strap,
  input wire logic bus_state_strap_n,
  input wire logic panel_power_on,
  output logic panel_power_out,
  output logic [2:0] bus_mode,
  output logic big_endian,
  output logic strobe_mode_active,
  input wire logic refresh_req,
  input wire logic [15:0] refresh_addr,
  output logic [15:0] refresh_data,
  output logic refresh_grant
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] swap16(input logic [15:0] d,
                                         input logic en);
    swap16 = en ? {d[7:0], d[15:8]} : d;
  endfunction : swap16

  store_if acc ();
  host_port_pkg::link_state_type l;
  host_port_pkg::link_state_type next_l;
  host_port_pkg::core_state_type c;
  host_port_pkg::core_state_type next_c;
  logic sel;
  logic any_write;
  logic any_read;
  logic strobe_cfg_ok;

  // ****************************************
  // Core domain: straps, crossing, panel power
  // ****************************************
  // Strap code is strobe mode only with bus-state low
  assign strobe_cfg_ok = c.taken && c.mode == `STROBE_MODE_CODE
    && c.bus_state == `STROBE_MODE_BUS_STATE; // RL13 RL9

  always_comb begin
    next_c = c;
    next_c.strap_s1 = {bus_mode_straps, byte_order_strap,
                       panel_power_polarity_strap, bus_state_strap_n};
    next_c.strap_s2 = c.strap_s1;
    // Caught once after release; later strap changes are ignored
    // Wait for the synchroniser to fill, or reset zeros are taken
    if (!c.taken && c.settle == `STRAP_SETTLE_EDGES) begin // RL10
      next_c.taken = 1'b1;
      next_c.mode = c.strap_s2[5:3];
      next_c.big = c.strap_s2[2]; // RL11
      next_c.polarity = c.strap_s2[1];
      next_c.bus_state = c.strap_s2[0];
    end else if (!c.taken) begin
      next_c.settle = c.settle + 2'h1;
    end
    next_c.power = c.polarity ? panel_power_on : !panel_power_on; // RL12
    next_c.req_s1 = l.req_tgl;
    next_c.req_s2 = c.req_s1;
    if (c.req_s2 != c.req_seen) begin
      next_c.req_seen = c.req_s2;
    end
    if (acc.done) begin
      next_c.ack_tgl = !c.ack_tgl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // Link holds these words stable until the ack toggle returns
  assign acc.start = c.req_s2 != c.req_seen;
  assign acc.write = l.write;
  assign acc.be = l.be;
  assign acc.addr = l.addr;
  assign acc.wdata = l.wdata;

  core_store u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .acc(acc),
    .refresh_req(refresh_req),
    .refresh_addr(refresh_addr),
    .refresh_data(refresh_data),
    .refresh_grant(refresh_grant)
  );

  assign panel_power_out = c.power;
  assign bus_mode = c.mode;
  assign big_endian = c.big;
  assign strobe_mode_active = strobe_cfg_ok;

  // ****************************************
  // Link domain on the host bus clock
  // ****************************************
  // Pins are synchronous to this clock, so no synchroniser here
  assign any_write = !write_strobe_low_n || !write_strobe_high_n;
  assign any_read = !read_strobe_low_n || !read_strobe_high_n;
  assign sel = !chip_select_n && (any_write || any_read);

  always_comb begin
    next_l = l;
    next_l.ok_s1 = strobe_cfg_ok;
    next_l.ok_s2 = l.ok_s1;
    next_l.big_s1 = c.big;
    next_l.big_s2 = l.big_s1;
    next_l.ack_s1 = c.ack_tgl;
    next_l.ack_s2 = l.ack_s1;
    unique case (l.phase)
      host_port_pkg::l_idle: begin
        // Bus-state pin is not looked at here
        if (sel && l.ok_s2) begin // RL9 RL13
          next_l.phase = host_port_pkg::l_busy;
          next_l.req_tgl = !l.req_tgl;
          next_l.write = any_write;
          next_l.addr = port_addr; // RL15
          next_l.wdata = swap16(port_data_in, l.big_s2); // RL11
          next_l.be = l.big_s2 ?
            {!write_strobe_low_n, !write_strobe_high_n} :
            {!write_strobe_high_n, !write_strobe_low_n}; // RL11
        end
      end
      host_port_pkg::l_busy: begin
        if (l.ack_s2 != l.ack_seen) begin // RL7 RL8
          next_l.ack_seen = l.ack_s2;
          next_l.rdata = swap16(acc.rdata, l.big_s2);
          next_l.phase = host_port_pkg::l_done;
        end
      end
      host_port_pkg::l_done: begin
        next_l.phase = host_port_pkg::l_hold;
      end
      host_port_pkg::l_hold: begin
        if (!sel) begin
          next_l.phase = host_port_pkg::l_idle;
        end
      end
    endcase
  end

  always_ff @(posedge host_port_clock or posedge rst) begin // RL1
    if (rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Low from the strobe's first cycle; no edge needed to stall
  assign wait_n = !(sel && l.ok_s2 &&
    (l.phase == host_port_pkg::l_idle ||
     l.phase == host_port_pkg::l_busy)); // RL7
  assign port_data_out = l.rdata;
  // Read data stays out while read strobe and select hold
  assign port_data_oe = !chip_select_n && any_read && !l.write &&
    (l.phase == host_port_pkg::l_done ||
     l.phase == host_port_pkg::l_hold); // RL21

  // ****************************************
  // Checks
  // ****************************************
  a_wait_on_start: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_idle && sel && l.ok_s2)
    |-> !wait_n ##1 (l.phase == host_port_pkg::l_busy)) // RL7
    else $error("wait not low at cycle start");
  a_wait_until_ack: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_busy && sel && l.ack_s2 == l.ack_seen)
    |-> !wait_n) // RL8
    else $error("wait released before grant");
  a_read_data_held: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_done && !l.write && !chip_select_n
     && any_read) |-> wait_n && port_data_oe
    ##1 ($stable(port_data_out))) // RL21
    else $error("read data not held at wait release");
  a_mode_gate: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_idle && !l.ok_s2)
    |=> (l.phase == host_port_pkg::l_idle && $stable(l.req_tgl))) // RL13
    else $error("access taken outside strobe mode");
  a_byte_order: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_idle && sel && l.ok_s2 && l.big_s2)
    |=> (l.wdata == {$past(port_data_in[7:0]),
                     $past(port_data_in[15:8])})) // RL11
    else $error("big-endian swap missing");
  a_straps_hold: assert property (@(posedge ref_clk) disable iff (rst)
    c.taken |=> ($stable(c.mode) && $stable(c.big)
                 && $stable(c.polarity) && c.taken)) // RL10
    else $error("configuration changed after capture");
  a_panel_polarity: assert property (@(posedge ref_clk) disable iff (rst)
    c.taken |=> (panel_power_out ==
                 ($past(panel_power_on) ~^ $past(c.polarity)))) // RL12
    else $error("panel power polarity wrong");
  a_hold_to_idle: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_hold && !sel)
    |=> (l.phase == host_port_pkg::l_idle)) // RL7
    else $error("link not released after strobes");

  // Quiet bus must see wait high, or other devices' cycles stall
  a_wait_idle_high: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (chip_select_n || !l.ok_s2) |-> wait_n) // RL7 RL9
    else $error("wait low outside a cycle");

  a_ack_release: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_busy && l.ack_s2 != l.ack_seen)
    |=> (l.phase == host_port_pkg::l_done && wait_n)) // RL7
    else $error("wait not released after store answer");

  // Read lanes swap the same way as write lanes
  a_read_lanes: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_busy && l.ack_s2 != l.ack_seen)
    |=> (port_data_out == ($past(l.big_s2) ?
         {$past(acc.rdata[7:0]), $past(acc.rdata[15:8])} :
         $past(acc.rdata)))) // RL11
    else $error("read lanes wrong");

  // Data lines are shared; drive them only for our own read
  a_oe_needs_read: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (chip_select_n || !any_read) |-> !port_data_oe) // RL21
    else $error("data driven outside a read");

  // Little-endian hosts put the low strobe on the low lane
  a_be_lanes: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_idle && sel && l.ok_s2 && !l.big_s2)
    |=> (l.be == {!$past(write_strobe_high_n),
                  !$past(write_strobe_low_n)})) // RL11
    else $error("byte enables on wrong lanes");

  // Only sixteen address pins exist, so the image repeats
  a_addr_taken: assert property (@(posedge host_port_clock)
    disable iff (rst)
    (l.phase == host_port_pkg::l_idle && sel && l.ok_s2)
    |=> (l.addr == $past(port_addr))) // RL15
    else $error("address not taken at cycle start");

  // ****************************************
  // Checks on the core clock
  // ****************************************
  a_strap_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (!c.taken && c.settle == `STRAP_SETTLE_EDGES)
    |=> (c.taken && c.mode == $past(c.strap_s2[5:3])
         && c.big == $past(c.strap_s2[2]))) // RL10
    else $error("straps not taken from synchroniser");

  a_mode_decode: assert property (@(posedge ref_clk) disable iff (rst)
    strobe_mode_active |-> (c.taken && bus_mode == `STROBE_MODE_CODE
      && c.bus_state == `STROBE_MODE_BUS_STATE)) // RL13
    else $error("strobe mode without matching straps");

  // One pulse per toggle, or the store would serve twice
  a_start_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    acc.start |=> !acc.start) // RL7
    else $error("store start longer than one cycle");
endmodule : host_port

// ---- sim/host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model (
  input wire logic host_port_clock,
  input wire logic wait_n,
  input wire logic [15:0] port_data_out,
  input wire logic port_data_oe,
  output logic chip_select_n,
  output logic [15:0] port_addr,
  output logic [15:0] port_data_in,
  output logic write_strobe_low_n,
  output logic write_strobe_high_n,
  output logic read_strobe_low_n,
  output logic read_strobe_high_n
);
  // ********************
  // Wires and glue
  // ********************
  logic drive = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic host_cycle_ack_n;
  initial begin
    chip_select_n = 1'b1;
    port_addr = 16'h0000;
    write_strobe_low_n = 1'b1;
    write_strobe_high_n = 1'b1;
    read_strobe_low_n = 1'b1;
    read_strobe_high_n = 1'b1;
  end
  // Gated so other cycles never see our acknowledge
  assign host_cycle_ack_n = chip_select_n ? 1'b1 : ~wait_n;
  // Low lanes of a little-endian host; a released bus drifts
  assign port_data_in = port_data_oe ? port_data_out
    : (drive ? wdata : ~last);
  always @(posedge host_port_clock) last <= port_data_in;
  // ********************
  // One host cycle
  // ********************
  task access(input logic wr, input logic [1:0] be, input logic [15:0] addr,
    input logic [15:0] data, input logic linger, output logic [15:0] rd,
    output logic [15:0] held, output int cyc, output logic oe_seen);
    @(posedge host_port_clock);
    chip_select_n <= 1'b0;
    port_addr <= addr;
    wdata <= data;
    drive <= wr;
    write_strobe_low_n <= !(wr && be[0]);
    write_strobe_high_n <= !(wr && be[1]);
    // Reads are whole words, never bursts
    read_strobe_low_n <= wr;
    read_strobe_high_n <= wr;
    cyc = 0;
    oe_seen = 1'b0;
    // No internal wait states: the acknowledge ends it, or the 400-cycle limit
    // Looked at mid-cycle, where the level stands as the edge takes it
    do begin
      @(negedge host_port_clock);
      cyc++;
      oe_seen = oe_seen | port_data_oe;
    end while (host_cycle_ack_n !== 1'b0 && cyc < 400);
    rd = port_data_in;
    held = rd;
    if (linger) begin
      @(negedge host_port_clock);
      held = port_data_in;
    end
    @(posedge host_port_clock);
    chip_select_n <= 1'b1;
    write_strobe_low_n <= 1'b1;
    write_strobe_high_n <= 1'b1;
    read_strobe_low_n <= 1'b1;
    read_strobe_high_n <= 1'b1;
    drive <= 1'b0;
    // Acknowledge must be gone before the next cycle
    @(posedge host_port_clock);
  endtask : access
endmodule : host_bus_model

// ---- sim/test_host_port.sv ----
`timescale 1ns/1ps
module test_host_port;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic host_port_clock = 1'b0;
  logic [2:0] bus_mode_straps = 3'h7;
  logic byte_order_strap = 1'b0;
  logic panel_power_polarity_strap = 1'b1;
  logic bus_state_strap_n = 1'b0;
  logic panel_power_on = 1'b0;
  logic refresh_req = 1'b0;
  logic [15:0] refresh_addr = 16'h0000;
  logic chip_select_n, port_data_oe, wait_n, panel_power_out;
  logic write_strobe_low_n, write_strobe_high_n;
  logic read_strobe_low_n, read_strobe_high_n;
  logic big_endian, strobe_mode_active, refresh_grant, oe_seen;
  logic [15:0] port_addr, port_data_in, port_data_out, refresh_data;
  logic [15:0] rd, held, a;
  logic [2:0] bus_mode, m;
  int cyc, n_fail = 0, n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  // Host clock free-runs, as a system clock does
  always #80 host_port_clock = ~host_port_clock;
  host_port u_dut (.ref_clk(ref_clk), .rst(rst),
    .host_port_clock(host_port_clock), .chip_select_n(chip_select_n),
    .port_addr(port_addr), .port_data_in(port_data_in),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .write_strobe_low_n(write_strobe_low_n),
    .write_strobe_high_n(write_strobe_high_n),
    .read_strobe_low_n(read_strobe_low_n),
    .read_strobe_high_n(read_strobe_high_n), .wait_n(wait_n),
    .bus_mode_straps(bus_mode_straps), .byte_order_strap(byte_order_strap),
    .panel_power_polarity_strap(panel_power_polarity_strap),
    .bus_state_strap_n(bus_state_strap_n), .panel_power_on(panel_power_on),
    .panel_power_out(panel_power_out), .bus_mode(bus_mode),
    .big_endian(big_endian), .strobe_mode_active(strobe_mode_active),
    .refresh_req(refresh_req), .refresh_addr(refresh_addr),
    .refresh_data(refresh_data), .refresh_grant(refresh_grant));
  host_bus_model u_host (.host_port_clock(host_port_clock), .wait_n(wait_n),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .chip_select_n(chip_select_n), .port_addr(port_addr),
    .port_data_in(port_data_in), .write_strobe_low_n(write_strobe_low_n),
    .write_strobe_high_n(write_strobe_high_n),
    .read_strobe_low_n(read_strobe_low_n),
    .read_strobe_high_n(read_strobe_high_n));
  // ********************
  // Shared tasks
  // ********************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task do_reset(input logic [2:0] md, input logic bs, input logic bo,
    input logic pol);
    @(posedge ref_clk);
    rst <= 1'b1;
    bus_mode_straps <= md;
    bus_state_strap_n <= bs;
    byte_order_strap <= bo;
    panel_power_polarity_strap <= pol;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge host_port_clock);
  endtask : do_reset
  task xfer(input logic wr, input logic [1:0] be, input logic [15:0] ad,
    input logic [15:0] d, input logic linger);
    u_host.access(wr, be, ad, d, linger, rd, held, cyc, oe_seen);
    check(16'(cyc < 400), 16'h0001);
  endtask : xfer
  task wr_rd(input logic [15:0] ad, input logic [15:0] d,
    input logic [15:0] exp);
    xfer(1'b1, 2'h3, ad, d, 1'b0);
    check(16'(oe_seen), 16'h0000);
    check(16'(cyc > 1), 16'h0001);
    xfer(1'b0, 2'h3, ad, 16'h0000, 1'b1);
    check(rd, exp);
    check(held, rd);
  endtask : wr_rd
  initial begin
    #500000;
    n_fail++;
    $display("watchdog expired");
    final_report();
  end
  // ********************
  // Tests
  // ********************
  initial begin
    for (int i = 0; i < 9; i++) begin
      m = (i < 8) ? 3'(i) : 3'h7;
      do_reset(m, i == 8, 1'b0, 1'b1);
      check(16'(bus_mode), 16'(m));
      check(16'(strobe_mode_active), 16'(m == 3'h7 && i != 8));
      check(16'(big_endian), 16'h0000);
    end
    // Shared-strobe mode: strobes must be ignored
    xfer(1'b0, 2'h3, 16'h0000, 16'h0000, 1'b0);
    check(16'(cyc), 16'h0001);
    check(16'(oe_seen), 16'h0000);
    $display("test strap decode done");
    do_reset(3'h7, 1'b0, 1'b1, 1'b0);
    check(16'(big_endian), 16'h0001);
    panel_power_on <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(16'(panel_power_out), 16'h0000);
    // Straps moved after capture must change nothing
    panel_power_on <= 1'b0;
    bus_mode_straps <= 3'h0;
    byte_order_strap <= 1'b0;
    panel_power_polarity_strap <= 1'b1;
    bus_state_strap_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check(16'(panel_power_out), 16'h0001);
    check(16'({big_endian, strobe_mode_active, bus_mode}), 16'h001F);
    wr_rd(16'h0010, 16'hA55A, 16'hA55A);
    $display("test strap hold done");
    do_reset(3'h7, 1'b0, 1'b0, 1'b1);
    panel_power_on <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(16'(panel_power_out), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 16'h0000 : (k == 1) ? 16'h9FFE
        : (k == 2) ? 16'hFFE0 : 16'hFFFE;
      wr_rd(a, a ^ 16'hC3A5, a ^ 16'hC3A5);
    end
    wr_rd(16'hA000, 16'h1234, 16'h0000);
    wr_rd(16'hFFDE, 16'h1234, 16'h0000);
    xfer(1'b1, 2'h1, 16'hFFFE, 16'h22AA, 1'b0);
    xfer(1'b1, 2'h2, 16'hFFFE, 16'hBB33, 1'b0);
    xfer(1'b0, 2'h3, 16'hFFFE, 16'h0000, 1'b0);
    check(rd, 16'hBBAA);
    $display("test access done");
    refresh_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(16'(refresh_grant), 16'h0001);
    fork
      xfer(1'b0, 2'h3, 16'h0000, 16'h0000, 1'b0);
      begin
        repeat (40) @(posedge ref_clk);
        check(16'(wait_n), 16'h0000);
        refresh_req <= 1'b0;
      end
    join
    check(rd, 16'hC3A5);
    check(16'(cyc > 5), 16'h0001);
    $display("test refresh collision done");
    final_report();
  end
endmodule : test_host_port
